/* hw/dsp4_block.sv */
// dsp4_block: multiplier/adder block with input shift chains
// assumes fabric inputs synchronous to clk_i, wishbone classic master
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module dsp4_block (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dsp4_pkg::dsp4_rows_t row_in_i,
  input wire logic [9:0] dl_left_i,
  input wire logic [9:0] dl_right_i,
  input wire dsp4_pkg::dsp4_ctl_s ctl_i,
  input wire dsp4_pkg::dsp4_op_t shift_in_i,
  input wire logic coef_shift_i,
  input wire dsp4_pkg::dsp4_op_t coef_in_i,
  output dsp4_pkg::dsp4_rows_t row_out_o,
  output dsp4_pkg::dsp4_link_t link_left_o,
  output dsp4_pkg::dsp4_link_t link_right_o,
  output dsp4_pkg::dsp4_op_t shift_out_o,
  output logic [71:0] cascade_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    dsp4_pkg::dsp4_cfg_s cfg;
    logic reject;
    dsp4_pkg::dsp4_op_t [3:0] xa;
    dsp4_pkg::dsp4_op_t [3:0] yb;
    dsp4_pkg::dsp4_p18_t [3:0] p18;
    dsp4_pkg::dsp4_p9_t [7:0] p9;
    dsp4_pkg::dsp4_p36_t p36;
    logic [1:0] up_d;
    logic [1:0] lo_d;
    dsp4_pkg::dsp4_sum_t [3:0] s;
    dsp4_pkg::dsp4_acc_t [1:0] acc;
    logic [143:0] res;
  } dsp4_state_s;

  dsp4_state_s st;
  dsp4_state_s next_st;

  logic cw_en;
  logic [1:0] cw_idx;
  dsp4_pkg::dsp4_op_t cw_dat;
  dsp4_pkg::dsp4_op_t [3:0] coef_q;
  logic up_app;
  logic lo_app;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // even rows take the low link wires, odd rows the high ones
  function automatic dsp4_pkg::dsp4_op_t opnd(input int unsigned r,
      input dsp4_pkg::dsp4_rows_t rows, input logic [7:0] sel,
      input logic [9:0] dl, input logic [9:0] dr);
    if (!sel[r]) begin
      opnd = rows[r];
    end else if (r[0]) begin
      opnd = {dl[9:1], dr[9:1]};
    end else begin
      opnd = {dl[8:0], dr[8:0]};
    end
  endfunction

  // signedness widens each operand by one bit before the product
  function automatic dsp4_pkg::dsp4_p18_t mul18(input dsp4_pkg::dsp4_op_t a,
      input dsp4_pkg::dsp4_op_t b, input logic sa, input logic sb);
    mul18 = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
  endfunction

  function automatic dsp4_pkg::dsp4_p9_t mul9(input logic [8:0] a,
      input logic [8:0] b, input logic sa, input logic sb);
    mul9 = $signed({sa & a[8], a}) * $signed({sb & b[8], b});
  endfunction

  // control latency select for an adder-stage control
  function automatic logic pick(input logic [1:0] lat, input logic raw,
      input logic [1:0] d);
    case (lat)
      dsp4_pkg::LAT_ONE: pick = d[0];
      dsp4_pkg::LAT_TWO: pick = d[1];
      default: pick = raw;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wr, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? wr[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // one mode, one product width; the wide mode has no adders inside
  function automatic logic cfg_ok(input dsp4_pkg::dsp4_cfg_s c);
    cfg_ok = $onehot(c.mode) && (c.size != dsp4_pkg::SZ_BAD)
      && ((c.size != dsp4_pkg::SZ_36)
      || (c.mode == dsp4_pkg::MODE_SIMPLE));
  endfunction

  // ---------------------------------------------------------------
  // adder controls after the selected latency
  // ---------------------------------------------------------------
  assign up_app = pick(st.cfg.lat, ctl_i.add_sub_select_upper, st.up_d);
  assign lo_app = pick(st.cfg.lat, ctl_i.add_sub_select_lower, st.lo_d);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [1:0] ci;
    dsp4_pkg::dsp4_cfg_s nc;
    dsp4_pkg::dsp4_stat_s stat;
    wv = '0;
    ci = 2'((wb_adr_i - dsp4_pkg::REG_COEF0) >> 2);
    nc = st.cfg;
    stat = '{sign_mismatch: ctl_i.sign_a ^ ctl_i.sign_b,
      reject: st.reject, mode: st.cfg.mode};
    next_st = st;
    cw_en = 1'b0;
    cw_idx = ci;
    cw_dat = '0;

    // wishbone slave: one-cycle answer, unmapped reads give zero
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st.rdat = '0;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      if (wb_adr_i == dsp4_pkg::REG_CTRL) begin
        next_st.rdat = 32'(st.cfg);
        if (wb_we_i) begin
          wv = merge(32'(st.cfg), wb_dat_i, wb_sel_i);
          nc = dsp4_pkg::dsp4_cfg_s'(wv[dsp4_pkg::CFG_W-1:0]);
          // an illegal mix is refused whole and flagged
          next_st.reject = !cfg_ok(nc);
          if (cfg_ok(nc)) begin
            next_st.cfg = nc;
          end
        end
      end else if (wb_adr_i == dsp4_pkg::REG_STATUS) begin
        next_st.rdat = 32'(stat);
      end else if (wb_adr_i >= dsp4_pkg::REG_COEF0 &&
          wb_adr_i <= dsp4_pkg::REG_COEF3 && wb_adr_i[1:0] == 2'h0) begin
        next_st.rdat = 32'(coef_q[ci]);
        if (wb_we_i) begin
          wv = merge(32'(coef_q[ci]), wb_dat_i, wb_sel_i);
          cw_en = 1'b1; // parallel coefficient load
          cw_dat = wv[17:0];
        end
      end
    end

    // operand stage: row units feed x and y lanes, or the chains run
    for (int i = 0; i < dsp4_pkg::TAPS; i++) begin
      // x rows 1,3,5,7 and y rows 2,4,6,8
      next_st.xa[i] = opnd(2*i, row_in_i, st.cfg.src_dl, dl_left_i, dl_right_i);
      next_st.yb[i] = opnd(2*i+1, row_in_i, st.cfg.src_dl, dl_left_i, dl_right_i);
      if (st.cfg.coef_par) begin
        next_st.yb[i] = coef_q[i];
      end
      if (st.cfg.chain_en) begin
        // sample chain across the four taps
        next_st.xa[i] = (i == 0) ? (st.cfg.chain_ext ? shift_in_i
          : st.xa[0]) : st.xa[i-1];
      end
    end
    if (st.cfg.chain_en && !st.cfg.chain_ext) begin
      next_st.xa[0] = opnd(0, row_in_i, st.cfg.src_dl, dl_left_i, dl_right_i);
    end

    // product stage; signedness applies to every lane alike
    for (int i = 0; i < dsp4_pkg::TAPS; i++) begin
      next_st.p18[i] = mul18(st.xa[i], st.yb[i], ctl_i.sign_a, ctl_i.sign_b);
      next_st.p9[2*i] = mul9(st.xa[i][8:0], st.yb[i][8:0],
        ctl_i.sign_a, ctl_i.sign_b);
      next_st.p9[2*i+1] = mul9(st.xa[i][17:9], st.yb[i][17:9],
        ctl_i.sign_a, ctl_i.sign_b);
    end
    // wide product from the first two pairs, upper halves carry sign
    next_st.p36 = $signed({ctl_i.sign_a & st.xa[1][17], st.xa[1], st.xa[0]})
      * $signed({ctl_i.sign_b & st.yb[1][17], st.yb[1], st.yb[0]});

    // control delay lines
    next_st.up_d = {st.up_d[0], ctl_i.add_sub_select_upper};
    next_st.lo_d = {st.lo_d[0], ctl_i.add_sub_select_lower};

    // first-stage adder/subtractors, high select adds
    if (st.cfg.size == dsp4_pkg::SZ_9) begin
      for (int k = 0; k < 4; k++) begin
        // pairs: top two use the upper select, bottom two the lower
        next_st.s[k] = (k < 2 ? up_app : lo_app)
          ? 39'($signed(st.p9[4*(k/2)+k%2])) + 39'($signed(st.p9[4*(k/2)+k%2+2]))
          : 39'($signed(st.p9[4*(k/2)+k%2])) - 39'($signed(st.p9[4*(k/2)+k%2+2]));
      end
    end else begin
      next_st.s[0] = up_app ? 39'($signed(st.p18[0])) + 39'($signed(st.p18[1]))
        : 39'($signed(st.p18[0])) - 39'($signed(st.p18[1]));
      next_st.s[1] = lo_app ? 39'($signed(st.p18[2])) + 39'($signed(st.p18[3]))
        : 39'($signed(st.p18[2])) - 39'($signed(st.p18[3]));
      next_st.s[2] = '0;
      next_st.s[3] = '0;
    end

    // accumulators fed by the second and fourth multipliers only
    for (int j = 0; j < 2; j++) begin
      logic [51:0] pv;
      logic sub;
      pv = (st.cfg.size == dsp4_pkg::SZ_9) ? 52'($signed(st.p9[4*j+2]))
        : 52'($signed(st.p18[2*j+1]));
      sub = (j == 0) ? !up_app : !lo_app;
      if (st.cfg.mode != dsp4_pkg::MODE_MAC) begin
        next_st.acc[j] = '0;
      end else if (ctl_i.acc_load[j]) begin
        next_st.acc[j] = pv;
      end else begin
        next_st.acc[j] = sub ? st.acc[j] - pv : st.acc[j] + pv;
      end
    end

    // output selection per mode; lanes widened by sign
    next_st.res = '0;
    case (st.cfg.mode)
      dsp4_pkg::MODE_SIMPLE: begin
        if (st.cfg.size == dsp4_pkg::SZ_36) begin
          next_st.res[0 +: 72] = st.p36[71:0];
        end else if (st.cfg.size == dsp4_pkg::SZ_9) begin
          for (int i = 0; i < 8; i++) begin
            next_st.res[18*i +: 18] = st.p9[i][17:0];
          end
        end else begin
          for (int i = 0; i < 4; i++) begin
            next_st.res[36*i +: 36] = st.p18[i][35:0];
          end
        end
      end
      dsp4_pkg::MODE_MAC: begin
        next_st.res[0 +: 72] = 72'($signed(st.acc[0]));
        next_st.res[72 +: 72] = 72'($signed(st.acc[1]));
      end
      dsp4_pkg::MODE_ADD2: begin
        if (st.cfg.size == dsp4_pkg::SZ_9) begin
          for (int k = 0; k < 4; k++) begin
            next_st.res[36*k +: 36] = 36'($signed(st.s[k]));
          end
        end else begin
          next_st.res[0 +: 72] = 72'($signed(st.s[0]));
          next_st.res[72 +: 72] = 72'($signed(st.s[1]));
        end
      end
      dsp4_pkg::MODE_ADD4: begin
        // second-stage adder; in 18-bit size s2/s3 are zero
        next_st.res[0 +: 72] = 72'($signed(st.s[0])) + 72'($signed(st.s[1]));
        next_st.res[72 +: 72] = 72'($signed(st.s[2])) + 72'($signed(st.s[3]));
      end
      default: next_st.res = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.cfg <= dsp4_pkg::CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  dsp4_coef_mem u_coef (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(cw_en),
    .idx_i(cw_idx),
    .dat_i(cw_dat),
    .shift_i(coef_shift_i), // serial coefficient load
    .shift_dat_i(coef_in_i),
    .q_o(coef_q)
  );

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign row_out_o = st.res; // result lanes a..h on rows 1..8
  assign shift_out_o = st.xa[3]; // chain continues below
  assign cascade_o = st.res[71:0];

  // low nine bits to the left row, high nine to the right
  for (genvar r = 0; r < dsp4_pkg::ROWS; r++) begin : g_link
    assign link_left_o[r] = st.res[18*r +: 9];
    assign link_right_o[r] = st.res[18*r+9 +: 9];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_add4_sum: assert property (
    (st.cfg.mode == dsp4_pkg::MODE_ADD4) |=> st.res[71:0] ==
      $past(72'($signed(st.s[0])) + 72'($signed(st.s[1]))))
    else $error("four-product sum wrong");
  chk_add4_nine: assert property (
    (st.cfg.mode == dsp4_pkg::MODE_ADD4 && st.cfg.size == dsp4_pkg::SZ_9)
      |=> st.res[143:72] == $past(72'($signed(st.s[2])) + 72'($signed(st.s[3]))))
    else $error("second nine-bit sum wrong");
  chk_size_legal: assert property (
    st.cfg.size != dsp4_pkg::SZ_BAD)
    else $error("illegal product width");
  chk_chain_shift: assert property (
    st.cfg.chain_en |=> st.xa[1] == $past(st.xa[0]) && st.xa[3] == $past(st.xa[2]))
    else $error("sample chain did not shift");
  chk_chain_out: assert property (
    (st.cfg.chain_en && st.cfg.chain_ext) [*5] |-> shift_out_o == $past(shift_in_i, 4))
    else $error("chain output not four taps late");
  chk_simple_out: assert property (
    (st.cfg.mode == dsp4_pkg::MODE_SIMPLE && st.cfg.size == dsp4_pkg::SZ_18)
      |=> row_out_o[1:0] == $past(st.p18[0][35:0]))
    else $error("simple product not on rows one and two");
  chk_no_mac36: assert property (
    st.cfg.mode == dsp4_pkg::MODE_MAC |-> st.cfg.size != dsp4_pkg::SZ_36)
    else $error("accumulator at wide size");
  chk_acc_load: assert property (
    (st.cfg.mode == dsp4_pkg::MODE_MAC && st.cfg.size == dsp4_pkg::SZ_18 && ctl_i.acc_load[0])
      |=> ##1 row_out_o[2:0] == 54'($signed($past(st.p18[1], 2))))
    else $error("accumulator load not seen on output");
  chk_no_add36: assert property (
    st.cfg.size == dsp4_pkg::SZ_36 |-> st.cfg.mode == dsp4_pkg::MODE_SIMPLE)
    else $error("adder mode at wide size");
  chk_sel_delay: assert property (
    (st.cfg.lat == dsp4_pkg::LAT_TWO) [*3] |-> up_app == $past(ctl_i.add_sub_select_upper, 2))
    else $error("upper select latency not two");
  chk_sub_low: assert property (
    (st.cfg.size == dsp4_pkg::SZ_18 && !up_app) |=>
      st.s[0] == $past(39'($signed(st.p18[0])) - 39'($signed(st.p18[1]))))
    else $error("low select did not subtract");
  chk_one_mode: assert property (
    $onehot(st.cfg.mode))
    else $error("more than one mode active");
  chk_bus_ack: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  cov_add4: cover property (st.cfg.mode == dsp4_pkg::MODE_ADD4 ##4 !rst_i);
  cov_mac: cover property (st.cfg.mode == dsp4_pkg::MODE_MAC && ctl_i.acc_load[0]);
  cov_chain: cover property ((st.cfg.chain_en && st.cfg.chain_ext) [*5]);
  cov_reject: cover property ($rose(st.reject));

endmodule // dsp4_block

/* hw/dsp4_pkg.sv */
// dsp4_pkg: constants, register map and carrier types of the dsp block
// assumes a single 20 MHz clock and a classic wishbone register bus
package dsp4_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned ROWS = 8;
  localparam int unsigned TAPS = 4;
  localparam int unsigned LANE_W = 72;
  localparam int unsigned SLOT_W = 36;
  localparam int unsigned HALF_W = 9;

  typedef logic [17:0] dsp4_op_t;
  typedef logic [37:0] dsp4_p18_t;
  typedef logic [19:0] dsp4_p9_t;
  typedef logic [73:0] dsp4_p36_t;
  typedef logic [38:0] dsp4_sum_t;
  typedef logic [51:0] dsp4_acc_t;
  typedef logic [7:0][17:0] dsp4_rows_t;
  typedef logic [7:0][8:0] dsp4_link_t;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COEF0 = 8'h08;
  localparam logic [7:0] REG_COEF3 = 8'h14;

  // ---------------------------------------------------------------
  // modes, sizes, control latency
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_SIMPLE = 4'h1,
    MODE_MAC = 4'h2,
    MODE_ADD2 = 4'h4,
    MODE_ADD4 = 4'h8
  } dsp4_mode_e;

  typedef enum logic [1:0] {
    SZ_9 = 2'h0,
    SZ_18 = 2'h1,
    SZ_36 = 2'h2,
    SZ_BAD = 2'h3
  } dsp4_size_e;

  localparam logic [1:0] LAT_NONE = 2'h0;
  localparam logic [1:0] LAT_ONE = 2'h1;
  localparam logic [1:0] LAT_TWO = 2'h2;

  // ctrl register layout, lsb = mode
  typedef struct packed {
    logic [7:0] src_dl;
    logic coef_par;
    logic chain_ext;
    logic chain_en;
    logic [1:0] lat;
    dsp4_size_e size;
    dsp4_mode_e mode;
  } dsp4_cfg_s;

  localparam int unsigned CFG_W = $bits(dsp4_cfg_s);

  localparam dsp4_cfg_s CFG_RST = '{
    src_dl: 8'h00, coef_par: 1'b0, chain_ext: 1'b0, chain_en: 1'b0,
    lat: LAT_NONE, size: SZ_18, mode: MODE_SIMPLE};

  // status register layout, lsb = mode
  typedef struct packed {
    logic sign_mismatch;
    logic reject;
    dsp4_mode_e mode;
  } dsp4_stat_s;

  // fabric control bus as seen by this one-clock model
  typedef struct packed {
    logic sign_a;
    logic sign_b;
    logic add_sub_select_upper;
    logic add_sub_select_lower;
    logic [1:0] acc_load;
  } dsp4_ctl_s;

endpackage

/* hw/dsp4_coef_mem.sv */
// dsp4_coef_mem: four filter coefficients, parallel write or serial shift
// assumes the owner never writes and shifts for the same word meaningfully
`timescale 1ns/1ps
module dsp4_coef_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] idx_i,
  input wire dsp4_pkg::dsp4_op_t dat_i,
  input wire logic shift_i,
  input wire dsp4_pkg::dsp4_op_t shift_dat_i,
  output dsp4_pkg::dsp4_op_t [3:0] q_o
);

  typedef struct packed {
    dsp4_pkg::dsp4_op_t [3:0] word;
  } dsp4_mem_s;

  dsp4_mem_s st;
  dsp4_mem_s next_st;

  // ---------------------------------------------------------------
  // update: parallel write wins over a serial shift
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (shift_i) begin
      next_st.word = {st.word[2:0], shift_dat_i};
    end
    if (wr_i) begin
      next_st.word[idx_i] = dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.word; // read data straight from the word registers

endmodule // dsp4_coef_mem

/* tb/dsp4_fabric.sv */
// dsp4_fabric: behavioural stand-in for the logic rows around the dsp block
// assumes the bench sets operands and controls by non-blocking assignment
`timescale 1ns/1ps
module dsp4_fabric (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dsp4_pkg::dsp4_rows_t rows_i,
  input wire dsp4_pkg::dsp4_ctl_s ctl_i,
  output dsp4_pkg::dsp4_rows_t row_in_o,
  output dsp4_pkg::dsp4_ctl_s ctl_o,
  output logic [9:0] dl_left_o,
  output logic [9:0] dl_right_o
);
  logic [9:0] walk;

  // row k always carries operand lane k, never reordered
  assign row_in_o = rows_i;
  // signedness, add/sub selects and loads come from this side
  assign ctl_o = ctl_i;
  // idle direct links toggle each cycle so a stale value never looks valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      walk <= 10'h155;
    end else begin
      walk <= ~walk;
    end
  end
  assign dl_left_o = walk;
  assign dl_right_o = ~walk;
endmodule // dsp4_fabric

/* tb/testbench.sv */
// testbench: register bus and datapath checks of the dsp block
// assumes dsp4_pkg, dsp4_block and dsp4_fabric are compiled before it
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  logic ack;
  logic cshift = 1'b0;
  dsp4_pkg::dsp4_op_t cdat = '0;
  dsp4_pkg::dsp4_op_t sin = '0;
  dsp4_pkg::dsp4_op_t sout;
  dsp4_pkg::dsp4_rows_t rows = '0;
  dsp4_pkg::dsp4_rows_t rin;
  dsp4_pkg::dsp4_rows_t rout;
  dsp4_pkg::dsp4_ctl_s ctl = '0;
  dsp4_pkg::dsp4_ctl_s fctl;
  dsp4_pkg::dsp4_link_t lnk_l;
  dsp4_pkg::dsp4_link_t lnk_r;
  logic [9:0] dl_l;
  logic [9:0] dl_r;
  logic [71:0] casc;
  logic [71:0] el;
  logic [71:0] er;
  logic [143:0] e_all;
  logic signed [71:0] p [4];
  // operand corners: most negative, minus one, small values
  dsp4_pkg::dsp4_op_t xs [4] = '{18'h3fff0, 18'h00123, 18'h20000, 18'h1ffff};
  dsp4_pkg::dsp4_op_t ys [4] = '{18'h00007, 18'h3ffff, 18'h1ffff, 18'h20000};
  logic [31:0] bad [5] = '{32'h28, 32'h13, 32'h31, 32'h22, 32'h24};
  int n_errors = 0;
  int n_tests = 0;
  int k;

  always #25 clk_i = ~clk_i;

  dsp4_fabric fab (.clk_i(clk_i), .rst_i(rst_i), .rows_i(rows), .ctl_i(ctl), .row_in_o(rin),
    .ctl_o(fctl), .dl_left_o(dl_l), .dl_right_o(dl_r));
  dsp4_block dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .row_in_i(rin), .dl_left_i(dl_l), .dl_right_i(dl_r), .ctl_i(fctl), .shift_in_i(sin),
    .coef_shift_i(cshift), .coef_in_i(cdat), .row_out_o(rout), .link_left_o(lnk_l),
    .link_right_o(lnk_r), .shift_out_o(sout), .cascade_o(casc));

  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_wide(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ---------------------------------------------------------------
  // wishbone classic master; waits for ack under a bound
  // ---------------------------------------------------------------
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // look at ack on every edge, the first one included
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t no bus answer", $time);
      print_verdict();
    end
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask

  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, q);
    chk_reg(q, exp);
  endtask

  // sum of four products; selects pick add or subtract per pair
  function automatic logic [71:0] sum4(input logic u, input logic l);
    return p[0] + (u ? p[1] : -p[1]) + p[2] + (l ? p[3] : -p[3]);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      p[i] = $signed(xs[i]) * $signed(ys[i]);
      e_all[i*36 +: 36] = p[i][35:0];
    end
    for (int r = 0; r < 8; r++) begin
      el[r*9 +: 9] = e_all[r*18 +: 9];
      er[r*9 +: 9] = e_all[r*18 + 9 +: 9];
    end
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_read(8'h00, 32'h11);
    wb_read(8'h04, 32'h01);
    wb_read(8'h20, 32'h0);
    // signed operands, both selects add
    @(posedge clk_i);
    ctl <= 6'h3c;
    for (int i = 0; i < 4; i++) begin
      rows[2*i] <= xs[i];
      rows[2*i+1] <= ys[i];
    end
    settle(2);
    chk_wide(rout[3:0], 72'h0);
    settle(1);
    chk_wide(rout[3:0], e_all[71:0]);
    chk_wide(rout[7:4], e_all[143:72]);
    chk_wide(lnk_l, el);
    chk_wide(lnk_r, er);
    chk_wide(casc, e_all[71:0]);
    wb_write(8'h00, 32'h18);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i);
      ctl.add_sub_select_upper <= c[1];
      ctl.add_sub_select_lower <= c[0];
      settle(6);
      chk_wide(rout[3:0], sum4(c[1], c[0]));
    end
    // select delay: first matching cycle after the select drops
    for (int lat = 0; lat < 3; lat++) begin
      wb_write(8'h00, 32'h18 | (lat << 6));
      @(posedge clk_i);
      ctl.add_sub_select_upper <= 1'b1;
      settle(6);
      @(posedge clk_i);
      ctl.add_sub_select_upper <= 1'b0;
      k = 0;
      do begin
        settle(1);
        k++;
      end while (rout[3:0] !== sum4(1'b0, 1'b1) && k < 10);
      chk_reg(k, 2 + lat);
    end
    // illegal mode and size mixes leave the mode untouched
    wb_write(8'h00, 32'h18);
    foreach (bad[i]) begin
      wb_write(8'h00, bad[i]);
      wb_read(8'h00, 32'h18);
      wb_read(8'h04, 32'h18);
    end
    wb_write(8'h00, 32'h18);
    wb_read(8'h04, 32'h08);
    @(posedge clk_i);
    ctl.sign_b <= 1'b0;
    wb_read(8'h04, 32'h28);
    // serial coefficient load, last shifted lands in word 0
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      cshift <= 1'b1;
      cdat <= ys[i];
    end
    @(posedge clk_i);
    cshift <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb_read(8'(8'h08 + 4 * i), {14'h0, ys[3-i]});
    end
    wb_write(8'h10, 32'h155aa);
    wb_read(8'h10, 32'h155aa);
    // parallel coefficients replace the y rows: words hold y4, y3, 155aa, y1
    ctl.sign_b <= 1'b1;
    wb_write(8'h00, 32'h411);
    settle(4);
    p[0] = $signed(xs[0]) * $signed(ys[3]);
    p[2] = $signed(xs[1]) * $signed(ys[2]);
    chk_wide(rout[3:0], {p[2][35:0], p[0][35:0]});
    // one wide product from the first two operand pairs
    wb_write(8'h00, 32'h21);
    settle(3);
    p[2] = $signed({xs[1], xs[0]}) * $signed({ys[1], ys[0]});
    chk_wide(rout[3:0], p[2]);
    // accumulators: load both, then the upper one adds for three cycles
    @(posedge clk_i);
    ctl.acc_load <= 2'b11;
    wb_write(8'h00, 32'h12);
    settle(4);
    chk_wide(rout[7:4], p[3]);
    @(posedge clk_i);
    ctl.acc_load <= 2'b10;
    ctl.add_sub_select_upper <= 1'b1;
    settle(3);
    chk_wide(rout[3:0], 3 * p[1]);
    // two sums of four nine-bit products, every lane signed
    wb_write(8'h00, 32'h08);
    settle(3);
    for (int i = 0; i < 4; i++) begin
      p[i] = $signed(xs[i][8:0]) * $signed(ys[i][8:0])
        + $signed(xs[i][17:9]) * $signed(ys[i][17:9]);
    end
    chk_wide(rout[3:0], p[0] + p[1]);
    chk_wide(rout[7:4], p[2] + p[3]);
    // sample chain taken from the block above and passed on
    wb_write(8'h00, 32'h318);
    @(posedge clk_i);
    sin <= 18'h2a5a5;
    settle(3);
    chk_wide({54'h0, sout}, 72'h0);
    settle(1);
    chk_wide({54'h0, sout}, {54'h0, 18'h2a5a5});
    print_verdict();
  end
endmodule // testbench
